// file: rtl/asop_area_outputs.sv
// Purpose: Area status outputs driven from arming events, each with an on/off pattern
// Assumes: Event inputs are one-cycle pulses synchronous to pclk; levels held by source
// Notes:   APB slave holds pulse times, bell time and bell options
module asop_area_outputs
  import asop_pkg::*;
#(
  parameter int unsigned TICK_COUNT = TICK_CYCLES,
  parameter int unsigned MIN_COUNT  = MIN_TICKS
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                alarm_ev,
  input  wire logic                alarm_bell_en,
  input  wire logic                alarm_retrigger,
  input  wire logic                tamper_ev,
  input  wire logic                keypad_login_ev,
  input  wire logic                exit_start_ev,
  input  wire logic                entry_start_ev,
  input  wire logic                arm_done_ev,
  input  wire logic                disarm_done_ev,
  input  wire logic                always_active_section_disarm_ev,
  input  wire logic                defer_start_ev,
  input  wire logic                arm_start_ev,
  input  wire logic                defer_cancel_ev,
  input  wire logic                arm_fail_ev,
  input  wire logic                fail_clear_ev,
  input  wire logic                bypass_present,
  input  wire logic                count_at_zero,
  input  wire logic                count_at_max,
  input  wire logic                all_closed,
  output logic [NUM_OUT-1:0]       area_out
);
  logic [NUM_OUT-1:0] active;
  logic [15:0]        pulse_cfg [NUM_OUT];
  logic [7:0]         bell_minutes;
  logic [1:0]         control;          // bit0 login silences bell, bit1 retrigger enable
  logic [23:0]        tick_cnt;
  logic               tick;
  logic [15:0]        min_cnt;
  logic               minute;
  logic [7:0]         bell_left;
  logic               bell_expire;
  logic               bell_start;
  logic               wr_en;
  logic               rd_en;
  logic               addr_ok;

  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign addr_ok = (paddr < A_PULSE_BASE + 12'(NUM_OUT * 4)) || (paddr == A_BELL_CFG) ||
                   (paddr == A_CONTROL) || (paddr == A_ACTIVE) || (paddr == A_OUTPUTS) ||
                   (paddr == A_BELL_LEFT);
  // Unaligned or unmapped addresses error, so software notices a bad map
  assign pslverr = psel && penable && (!addr_ok || (paddr[1:0] != 2'b00));

  // 100 ms tick prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt >= 24'(TICK_COUNT - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 24'd1;
      tick     <= 1'b0;
    end
  end

  // Minute strobe built from 100 ms ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_cnt <= '0;
      minute  <= 1'b0;
    end else begin
      minute <= 1'b0;
      if (tick) begin
        if (min_cnt >= 16'(MIN_COUNT - 1)) begin
          min_cnt <= '0;
          minute  <= 1'b1;
        end else begin
          min_cnt <= min_cnt + 16'd1;
        end
      end
    end
  end

  // Configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bell_minutes <= BELL_MIN_RST;
      control      <= CONTROL_RST;
      for (int i = 0; i < NUM_OUT; i++) begin
        pulse_cfg[i] <= PULSE_RST;
      end
    end else if (wr_en && !pslverr) begin
      if (paddr == A_BELL_CFG) begin
        bell_minutes <= pwdata[7:0];
      end
      if (paddr == A_CONTROL) begin
        control <= pwdata[1:0];
      end
      for (int i = 0; i < NUM_OUT; i++) begin
        if (paddr == A_PULSE_BASE + 12'(i * 4)) begin
          pulse_cfg[i] <= pwdata[15:0];
        end
      end
    end
  end

  // Read mux, registered so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= '0;
      if (paddr == A_BELL_CFG) prdata <= {24'h0, bell_minutes};
      if (paddr == A_CONTROL) prdata <= {30'h0, control};
      if (paddr == A_ACTIVE) prdata <= {20'h0, active};
      if (paddr == A_OUTPUTS) prdata <= {20'h0, area_out};
      if (paddr == A_BELL_LEFT) prdata <= {24'h0, bell_left};
      for (int i = 0; i < NUM_OUT; i++) begin
        if (paddr == A_PULSE_BASE + 12'(i * 4)) prdata <= {16'h0, pulse_cfg[i]};
      end
    end
  end

  // Bell starts on a bell-enabled alarm; reload on retrigger if already running
  assign bell_start = alarm_ev && alarm_bell_en &&
                      (!active[O_BELL] || (control[1] && alarm_retrigger));
  assign bell_expire = minute && active[O_BELL] && (bell_left <= 8'd1);

  // Bell timer in minutes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bell_left <= '0;
    end else if (bell_start) begin
      bell_left <= bell_minutes;
    end else if (minute && bell_left != '0) begin
      bell_left <= bell_left - 8'd1;
    end
  end

  // Bell activity; a zero bell time means the bell never sounds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active[O_BELL] <= 1'b0;
    end else if (bell_start && bell_minutes != '0) begin
      active[O_BELL] <= 1'b1;
    end else if (bell_expire || disarm_done_ev) begin
      active[O_BELL] <= 1'b0;
    end else if (keypad_login_ev && control[0]) begin
      active[O_BELL] <= 1'b0;
    end
  end

  // Exit delay: start wins over a same-cycle stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active[O_EXIT] <= 1'b0;
    end else if (exit_start_ev) begin
      active[O_EXIT] <= 1'b1;
    end else if (arm_done_ev || disarm_done_ev) begin
      active[O_EXIT] <= 1'b0;
    end else if (alarm_ev) begin
      active[O_EXIT] <= 1'b0;
    end
  end

  // Entry delay ends on disarm or when the timeout raises the alarm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active[O_ENTRY] <= 1'b0;
    end else if (entry_start_ev) begin
      active[O_ENTRY] <= 1'b1;
    end else if (disarm_done_ev || alarm_ev) begin
      active[O_ENTRY] <= 1'b0;
    end
  end

  // Armed and disarmed indications are complements once a completion arrives; both are off from reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active[O_DISARM] <= 1'b0;
      active[O_ARMED]  <= 1'b0;
    end else if (disarm_done_ev) begin
      active[O_DISARM] <= 1'b1;
      active[O_ARMED]  <= 1'b0;
    end else if (arm_done_ev) begin
      active[O_DISARM] <= 1'b0;
      active[O_ARMED]  <= 1'b1;
    end
  end

  // Bypass indication; a present bypass wins over the disarm clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active[O_BYPASS] <= 1'b0;
    end else if (bypass_present) begin
      active[O_BYPASS] <= 1'b1;
    end else if (disarm_done_ev) begin
      active[O_BYPASS] <= 1'b0;
    end
  end

  // Tamper and alarm memory latch; the set wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active[O_TAMPER] <= 1'b0;
      active[O_MEMORY] <= 1'b0;
    end else begin
      if (tamper_ev) begin
        active[O_TAMPER] <= 1'b1;
      end else if (always_active_section_disarm_ev) begin
        active[O_TAMPER] <= 1'b0;
      end
      if (alarm_ev || tamper_ev) begin
        active[O_MEMORY] <= 1'b1;
      end else if (disarm_done_ev) begin
        active[O_MEMORY] <= 1'b0;
      end
    end
  end

  // Level-following indications
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active[O_COUNT] <= 1'b0;
      active[O_READY] <= 1'b0;
    end else begin
      active[O_COUNT] <= count_at_zero || count_at_max;
      active[O_READY] <= all_closed;
    end
  end

  // Defer warning and arm failure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active[O_DEFER] <= 1'b0;
      active[O_FAIL]  <= 1'b0;
    end else begin
      if (defer_start_ev) begin
        active[O_DEFER] <= 1'b1;
      end else if (arm_start_ev || defer_cancel_ev) begin
        active[O_DEFER] <= 1'b0;
      end
      // Clears on a later arming start or explicit clear
      if (arm_fail_ev) begin
        active[O_FAIL] <= 1'b1;
      end else if (fail_clear_ev || arm_start_ev) begin
        active[O_FAIL] <= 1'b0;
      end
    end
  end

  // One independent pattern generator per output
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_chan
    asop_pulse_chan #(
      .W (PULSE_W)
    ) u_chan (
      .pclk     (pclk),
      .presetn  (presetn),
      .tick     (tick),
      .active   (active[g]),
      .on_time  (pulse_cfg[g][7:0]),
      .off_time (pulse_cfg[g][15:8]),
      .out      (area_out[g])
    );
  end
endmodule : asop_area_outputs

// file: rtl/asop_pkg.sv
// Purpose: Constants for the area status output pulser
// Assumes: pclk at 10 MHz, APB register access
// Notes:   Register offsets are byte addresses of aligned 32-bit words
//
// Operation
// - Bell turns on at alarm only when the causing input has bell enabled.
// - Bell turns off on bell timer expiry or disarm, whichever first.
// - Bell may also be silenced by a keypad user login.
// - Active pulsed output runs on time, off time, repeating forever.
// - On and off settings count in 100 ms units.
// - A zero on or off setting makes the active output steady on.
// - On and off settings reach 255 units, 25.5 s per phase.
// - Exit output on at exit delay start, off at armed or disarmed.
// - Exit output also off on alarm during exit delay.
// - Entry output on at entry delay start, off at disarm or alarm.
// - Disarmed output on at disarm complete, off at arm complete.
// - Armed output on at arm complete, off at disarm complete.
// - Bypass output on while any input bypassed, off at disarm complete.
// - Tamper output on at tamper, off only at always-active section disarm.
// - Alarm memory latches on any alarm until disarm complete.
// - User count output on when count reaches zero or maximum.
// - Defer output on at defer warning start, off at arming or cancel.
// - Fail output on whenever an arming attempt fails.
// - Ready output on when all inputs and trouble inputs are closed.
// - Bell timer counts minutes; retrigger reloads it on each new alarm.
package asop_pkg;
  localparam int unsigned NUM_OUT      = 12;
  localparam int unsigned CLK_HZ       = 10000000;
  localparam int unsigned TICK_MS      = 100;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned MIN_TICKS    = 600;
  localparam int unsigned PULSE_W      = 8;
  // Output indices
  localparam int unsigned O_BELL   = 0;
  localparam int unsigned O_EXIT   = 1;
  localparam int unsigned O_ENTRY  = 2;
  localparam int unsigned O_DISARM = 3;
  localparam int unsigned O_ARMED  = 4;
  localparam int unsigned O_BYPASS = 5;
  localparam int unsigned O_TAMPER = 6;
  localparam int unsigned O_MEMORY = 7;
  localparam int unsigned O_COUNT  = 8;
  localparam int unsigned O_DEFER  = 9;
  localparam int unsigned O_FAIL   = 10;
  localparam int unsigned O_READY  = 11;
  // Register map
  localparam logic [11:0] A_PULSE_BASE = 12'h000;
  localparam logic [11:0] A_BELL_CFG   = 12'h040;
  localparam logic [11:0] A_CONTROL    = 12'h044;
  localparam logic [11:0] A_ACTIVE     = 12'h048;
  localparam logic [11:0] A_OUTPUTS    = 12'h04c;
  localparam logic [11:0] A_BELL_LEFT  = 12'h050;
  localparam logic [7:0]  BELL_MIN_RST = 8'h04;
  localparam logic [1:0]  CONTROL_RST  = 2'h1;
  localparam logic [15:0] PULSE_RST    = 16'h0000;
endpackage : asop_pkg

// file: rtl/asop_pulse_chan.sv
// Purpose: One pulsed output channel with its own phase timer
// Assumes: tick is a one-cycle pulse every 100 ms
// Notes:   Phase counter is private to the channel
module asop_pulse_chan
  import asop_pkg::*;
#(
  parameter int unsigned W = PULSE_W
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         tick,
  input  wire logic         active,
  input  wire logic [W-1:0] on_time,
  input  wire logic [W-1:0] off_time,
  output logic              out
);
  logic         was_active;
  logic         in_off;
  logic [W-1:0] left;
  logic         steady;

  // Zero in either field means steady on
  assign steady = (on_time == '0) || (off_time == '0);

  // Phase timer; restarts in the on phase on every rising activation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      was_active <= 1'b0;
      in_off     <= 1'b0;
      left       <= '0;
      out        <= 1'b0;
    end else begin
      was_active <= active;
      if (!active) begin
        in_off <= 1'b0;
        out    <= 1'b0;
      end else if (!was_active || steady) begin
        in_off <= 1'b0;
        left   <= on_time;
        out    <= 1'b1;
      end else if (tick) begin
        // Each phase lasts its setting in 100 ms ticks
        if (left <= W'(1)) begin
          in_off <= !in_off;
          left   <= in_off ? on_time : off_time;
          out    <= in_off;
        end else begin
          left <= left - W'(1);
        end
      end
    end
  end
endmodule : asop_pulse_chan

// file: bench/asop_area_outputs_assertions.sv
// Purpose: Port checks for the area status outputs
// Assumes: Events are one-cycle pulses; outputs answer two edges later
// Notes:   Phase settings are tracked from writes; pulsed outputs are checked on release only
module asop_area_outputs_assertions
  import asop_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        alarm_ev,
  input wire logic        tamper_ev,
  input wire logic        exit_start_ev,
  input wire logic        entry_start_ev,
  input wire logic        arm_done_ev,
  input wire logic        disarm_done_ev,
  input wire logic        always_active_section_disarm_ev,
  input wire logic        defer_start_ev,
  input wire logic        arm_start_ev,
  input wire logic        defer_cancel_ev,
  input wire logic        arm_fail_ev,
  input wire logic [11:0] area_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] z;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // A zero phase makes an output steady, so only then is its level known while active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      z <= '1;
    end else if (psel && penable && pwrite && paddr < 12'h030 && paddr[1:0] == 2'h0) begin
      z[paddr[5:2]] <= pwdata[7:0] == 8'h00 || pwdata[15:8] == 8'h00;
    end
  end
  sequence s_exit_stop;
    (alarm_ev || arm_done_ev || disarm_done_ev) && !exit_start_ev;
  endsequence
  sequence s_tamper_kept;
    tamper_ev && z[O_TAMPER] ##1 !always_active_section_disarm_ev [*3];
  endsequence
  // A start wins over a stop in one cycle, so stops are judged without a start
  AST_EXIT_ON: assert property (exit_start_ev && z[O_EXIT] |-> ##2 area_out[O_EXIT])
    else $error("exit output not on after exit start");
  AST_EXIT_OFF: assert property (s_exit_stop |-> ##2 !area_out[O_EXIT])
    else $error("exit output still on after a stop");
  AST_ENTRY_OFF: assert property (
    (disarm_done_ev || alarm_ev) && !entry_start_ev |-> ##2 !area_out[O_ENTRY])
    else $error("entry output still on after a stop");
  AST_ARMED_ON: assert property (
    arm_done_ev && !disarm_done_ev && z[O_ARMED] |-> ##2 area_out[O_ARMED] && !area_out[O_DISARM])
    else $error("armed and disarmed outputs wrong after arming");
  AST_DISARMED_ON: assert property (
    disarm_done_ev && !arm_done_ev && z[O_DISARM] |-> ##2 area_out[O_DISARM] && !area_out[O_ARMED])
    else $error("armed and disarmed outputs wrong after disarming");
  AST_TAMPER_HOLD: assert property (s_tamper_kept |-> area_out[O_TAMPER])
    else $error("tamper output dropped without section disarm");
  AST_DEFER_OFF: assert property (
    (arm_start_ev || defer_cancel_ev) && !defer_start_ev |-> ##2 !area_out[O_DEFER])
    else $error("defer output still on after arming or cancel");
  AST_FAIL_ON: assert property (arm_fail_ev && z[O_FAIL] |-> ##2 area_out[O_FAIL])
    else $error("fail output not on after failed arming");
endmodule : asop_area_outputs_assertions

bind asop_area_outputs asop_area_outputs_assertions u_asop_area_outputs_assertions (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .alarm_ev, .tamper_ev,
  .exit_start_ev, .entry_start_ev, .arm_done_ev, .disarm_done_ev,
  .always_active_section_disarm_ev, .defer_start_ev, .arm_start_ev, .defer_cancel_ev,
  .arm_fail_ev, .area_out);

// file: bench/asop_load_model.sv
// Purpose: Load on the area outputs, as a bell or relay sees them
// Assumes: One pclk domain
// Notes:   Only the bell line is timed; the rest are plain loads
module asop_load_model
  import asop_pkg::*;
(
  input  wire logic [11:0] area_out,
  input  wire logic        pclk,
  input  wire logic        presetn,
  output logic      [15:0] hi_len
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] run;
  // Length of the last whole high phase, so a short first phase is overwritten
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 16'h0000;
      hi_len <= 16'h0000;
    end else if (area_out[O_BELL]) begin
      run <= run + 16'h0001;
    end else begin
      run <= 16'h0000;
      if (run != 16'h0000) hi_len <= run;
    end
  end
endmodule : asop_load_model

// file: bench/test_area_status_output_pulser.sv
// Purpose: Self-checking bench for the area status outputs
// Assumes: Zero-wait APB; tick and minute counts shortened
// Notes:   Each read queues its expected word; a monitor judges it
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected %0t got %h want %h", $time, a, e); end end
module test_area_status_output_pulser
  import asop_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  // Event index in the top nibble, expected outputs below it
  localparam logic [15:0] STEPS [17] = '{16'h3002, 16'h5010, 16'h3012, 16'h0090, 16'h4094,
    16'h6008, 16'h8208, 16'h9008, 16'h8208, 16'ha008, 16'hb408, 16'h9008, 16'hb408,
    16'hc008, 16'h10c8, 16'h6048, 16'h7008};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        ben = 1'b0;
  logic        rtg = 1'b0;
  logic        pready;
  logic        pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] seed = 32'h467c967c;
  logic [32:0] q[$];
  logic [32:0] exp_word;
  logic [32:0] got_word;
  int          wait_n;
  logic [12:0] ev = 13'h0000;
  logic [3:0]  lv = 4'h0;
  logic [11:0] area_out;
  logic [15:0] hi_len;
  int          fail_count = 0;
  int          checks_done = 0;
  always #50 pclk = ~pclk;
  asop_area_outputs #(.TICK_COUNT(10), .MIN_COUNT(3)) u_asop_area_outputs (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .alarm_ev(ev[0]), .alarm_bell_en(ben), .alarm_retrigger(rtg), .tamper_ev(ev[1]),
    .keypad_login_ev(ev[2]), .exit_start_ev(ev[3]), .entry_start_ev(ev[4]),
    .arm_done_ev(ev[5]), .disarm_done_ev(ev[6]), .always_active_section_disarm_ev(ev[7]),
    .defer_start_ev(ev[8]), .arm_start_ev(ev[9]), .defer_cancel_ev(ev[10]),
    .arm_fail_ev(ev[11]), .fail_clear_ev(ev[12]), .bypass_present(lv[0]),
    .count_at_zero(lv[1]), .count_at_max(lv[2]), .all_closed(lv[3]), .area_out);
  asop_load_model u_asop_load_model (.pclk, .presetn, .area_out, .hi_len);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic final_report();
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // Read data is judged at the edge that completes the access
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      // Pop once, so a mismatch cannot slip the queue out of step
      exp_word = q.pop_front();
      got_word = {pslverr, prdata};
      `CHK(got_word, exp_word)
    end
  end
  // One APB transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      final_report();
    end
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back({1'b0, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Events are single-cycle; three edges let the output settle
  task automatic fire(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev <= 13'h0000;
    repeat (3) @(posedge pclk);
  endtask : fire
  task automatic lev(input logic [3:0] v, input logic [11:0] e);
    @(posedge pclk);
    lv <= v;
    repeat (3) @(posedge pclk);
    rd(A_OUTPUTS, {20'h0, e});
  endtask : lev
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, an unmapped place and a read-only place
    rd(A_BELL_CFG, {24'h0, BELL_MIN_RST});
    rd(A_CONTROL, {30'h0, CONTROL_RST});
    q.push_back({1'b1, 32'h0});  // Unmapped place answers with an error
    apb(1'b0, 12'h0fc, 32'h0);
    apb(1'b1, A_OUTPUTS, 32'hfff);
    rd(A_OUTPUTS, 32'h0);
    // Random phases read back, then cleared so that the outputs run steady
    for (int i = 0; i < NUM_OUT; i++) begin
      seed = lfsr(seed);
      rd(A_PULSE_BASE + 12'(4 * i), {16'h0, PULSE_RST});
      apb(1'b1, A_PULSE_BASE + 12'(4 * i), {16'h0, seed[15:0]});
      rd(A_PULSE_BASE + 12'(4 * i), {16'h0, seed[15:0]});
      apb(1'b1, A_PULSE_BASE + 12'(4 * i), 32'h0);
    end
    for (int i = 0; i < 17; i++) begin
      fire(int'(STEPS[i][15:12]));
      rd(A_OUTPUTS, {20'h0, STEPS[i][11:0]});
    end
    // Bypass is kept until a disarm finds none left
    lev(4'hb, 12'h928);
    lev(4'h4, 12'h128);
    fire(6);
    rd(A_OUTPUTS, 32'h108);
    lev(4'h0, 12'h008);
    // Bell pulses 2 on, 3 off until its minutes run out
    ben <= 1'b1;
    apb(1'b1, A_PULSE_BASE, 32'h0302);
    fire(0);
    repeat (48) @(posedge pclk);
    rd(A_ACTIVE, 32'h089);
    repeat (28) @(posedge pclk);
    `CHK(hi_len, 16'h0014)
    repeat (60) @(posedge pclk);
    rd(A_ACTIVE, 32'h088);
    fire(0);
    fire(2);
    rd(A_ACTIVE, 32'h088);
    fire(0);
    fire(6);
    rd(A_ACTIVE, 32'h008);
    // Steady bell of 2 minutes; its expiry marks a minute edge, so the next is 30 cycles on
    apb(1'b1, A_PULSE_BASE, 32'h0);
    apb(1'b1, A_BELL_CFG, 32'h2);
    apb(1'b1, A_CONTROL, 32'h3);
    rtg <= 1'b1;
    fire(0);
    wait_n = 0;
    do begin
      @(posedge pclk);
      wait_n++;
    end while (area_out[O_BELL] && wait_n < 100);
    if (wait_n >= 100) begin
      fail_count++;
      final_report();
    end
    // One minute passes on the new bell, then a retrigger reloads it before the next
    fire(0);
    repeat (30) @(posedge pclk);
    fire(0);
    rd(A_BELL_LEFT, 32'h2);
    // With the login option off a keypad login leaves the bell running
    apb(1'b1, A_CONTROL, 32'h2);
    fire(2);
    rd(A_ACTIVE, 32'h089);
    final_report();
  end
endmodule : test_area_status_output_pulser
